/* rtl/ctmc_edge_detect.sv */
/*
  edge detector: selects a source per channel and reports a one-cycle
  event on the programmed edge.
  assumes sources are already synchronised to clk.
*/
`timescale 1ns/100ps
module ctmc_edge_detect
    import ctmc_pkg::*;
(
    input  wire logic clk,    // gated peripheral clock
    input  wire logic rst_n,  // synchronised reset, active low
    ctmc_edge_if.det  edges   // edge carrier
);

    // ------------------------------------------------------------
    // per-channel selection and detection
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic sel_level;
            logic prev_q;
            assign sel_level = edges.sources[edges.src_sel[ch]];
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    prev_q <= 1'b0;
                end else begin
                    prev_q <= sel_level;
                end
            end
            assign edges.event_hit[ch] = edges.polarity[ch] ? (sel_level & ~prev_q)
                                                            : (~sel_level & prev_q);
        end
    endgenerate

endmodule : ctmc_edge_detect

/* rtl/ctmc_edge_if.sv */
/*
  carrier between the top and the edge detector: synchronised edge
  sources, per-channel selection and polarity, and detected events.
  assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface ctmc_edge_if;
    logic [3:0] sources;     // pin_a, pin_b, ccp_a, ccp_b at bits 3..0
    logic [1:0] src_sel [2]; // source select per channel
    logic [1:0] polarity;    // 1 rising, 0 falling per channel
    logic [1:0] event_hit;   // one-cycle edge event per channel

    modport top (output sources, output src_sel, output polarity, input event_hit);
    modport det (input sources, input src_sel, input polarity, output event_hit);
endinterface : ctmc_edge_if

/* rtl/ctmc_pkg.sv */
/*
  package of the charge-time measurement control block: register indices,
  field positions, reset values, source codes and range codes.
  assumes nothing of its surroundings.
*/
package ctmc_pkg;

    // register indices on the plain register port
    localparam logic [1:0] CTMC_ADDR_CTRL_HIGH   = 2'h0;
    localparam logic [1:0] CTMC_ADDR_CTRL_LOW    = 2'h1;
    localparam logic [1:0] CTMC_ADDR_CURRENT     = 2'h2;

    // reset values
    localparam logic [7:0] CTMC_RESET_CTRL_HIGH  = 8'h00;
    localparam logic [7:0] CTMC_RESET_CTRL_LOW   = 8'h00;
    localparam logic [7:0] CTMC_RESET_CURRENT    = 8'h00;

    // implemented bits of the first control register
    localparam logic [7:0] CTMC_HIGH_IMPL_MASK   = 8'hbf;

    // field positions, first control register
    localparam int CTMC_BIT_UNIT_ENABLE          = 7;
    localparam int CTMC_BIT_STOP_IN_IDLE         = 5;
    localparam int CTMC_BIT_DELAY_GEN_ENABLE     = 4;
    localparam int CTMC_BIT_EDGE_PASS_ENABLE     = 3;
    localparam int CTMC_BIT_EDGE_ORDER_ENABLE    = 2;
    localparam int CTMC_BIT_CURRENT_GROUND       = 1;
    localparam int CTMC_BIT_SPECIAL_TRIG_ENABLE  = 0;

    // field positions, second control register
    localparam int CTMC_BIT_SECOND_POLARITY      = 7;
    localparam int CTMC_POS_SECOND_SOURCE        = 5;
    localparam int CTMC_BIT_FIRST_POLARITY       = 4;
    localparam int CTMC_POS_FIRST_SOURCE         = 2;
    localparam int CTMC_BIT_SECOND_SEEN          = 1;
    localparam int CTMC_BIT_FIRST_SEEN           = 0;

    // field positions, current control register
    localparam int CTMC_POS_TRIM                 = 2;
    localparam int CTMC_POS_RANGE                = 0;

    // edge source codes
    localparam logic [1:0] CTMC_SRC_PIN_A        = 2'h3;
    localparam logic [1:0] CTMC_SRC_PIN_B        = 2'h2;
    localparam logic [1:0] CTMC_SRC_CCP_A        = 2'h1;
    localparam logic [1:0] CTMC_SRC_CCP_B        = 2'h0;

    // current range codes
    localparam logic [1:0] CTMC_RANGE_X100       = 2'h3;
    localparam logic [1:0] CTMC_RANGE_X10        = 2'h2;
    localparam logic [1:0] CTMC_RANGE_BASE       = 2'h1;
    localparam logic [1:0] CTMC_RANGE_OFF        = 2'h0;

    // delay pulse sequencer states
    typedef enum logic [2:0] {
        CTMC_PLS_IDLE = 3'b001,
        CTMC_PLS_HIGH = 3'b010,
        CTMC_PLS_DONE = 3'b100
    } ctmc_pulse_state_type;

endpackage : ctmc_pkg

/* rtl/ctmc_top.sv */
/*
  charge-time measurement control: three 8-bit control registers on a
  plain register port, edge capture into two status flags, current
  source and delay pulse control.
  assumes a 50 MHz clock, the analog parts and comparator outside, and
  edge pins asynchronous to clk.
*/
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/100ps
module ctmc_top
    import ctmc_pkg::*;
(
    input  wire logic       clk,                  // peripheral clock, 50 MHz
    input  wire logic       nrst,                 // async reset, active low
    input  wire logic       module_clock_disable, // gates the unit clock off
    input  wire logic       idle_mode,            // device in idle
    input  wire logic       sleep_mode,           // device in any sleep mode
    input  wire logic [1:0] reg_addr,             // register index
    input  wire logic [7:0] reg_wdata,            // write data
    input  wire logic       reg_write,            // write strobe
    input  wire logic       reg_read,             // read strobe
    output logic      [7:0] reg_rdata,            // read data, cycle after strobe
    input  wire logic       edge_pin_a,           // edge pin a, asynchronous
    input  wire logic       edge_pin_b,           // edge pin b, asynchronous
    input  wire logic       capture_compare_a,    // ccp a trigger, same clock
    input  wire logic       capture_compare_b,    // ccp b trigger, same clock
    input  wire logic       comparator_trip,      // pulse capacitor reached reference
    output logic            current_source_on,    // current source drives
    output logic            current_source_ground,// source output grounded
    output logic      [1:0] current_range,        // range code to analog
    output logic      [5:0] current_trim,         // signed trim to analog
    output logic            delay_pulse_pin,      // delay pulse output
    output logic            special_trigger       // special event trigger pulse
);

    // ------------------------------------------------------------
    // clock gating and reset release
    // ------------------------------------------------------------
    logic gate_en_q;
    logic uclk;
    logic rst_meta_q;
    logic rst_n_q;

    // latch-style gate enable sampled on the low phase to avoid glitches
    always_latch begin
        if (!clk) begin
            gate_en_q = ~module_clock_disable;
        end
    end
    assign uclk = clk & gate_en_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] async_in;
    logic [2:0] async_s;
    logic       pin_a_s;
    logic       pin_b_s;
    logic       trip_s;

    assign async_in = {edge_pin_a, edge_pin_b, comparator_trip};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            logic [2:0] sync_q;
            logic       level_q;
            always_ff @(posedge uclk or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    sync_q  <= 3'h0;
                    level_q <= 1'b0;
                end else begin
                    sync_q <= {sync_q[1:0], async_in[gi]};
                    // a change counts once the second and third stages agree
                    if (sync_q[1] == sync_q[2]) begin
                        level_q <= sync_q[2];
                    end
                end
            end
            assign async_s[gi] = level_q;
        end
    endgenerate

    assign pin_a_s = async_s[2];
    assign pin_b_s = async_s[1];
    assign trip_s  = async_s[0];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_high_q;
    logic [7:0] ctrl_high_d;
    logic [7:0] ctrl_low_q;
    logic [7:0] ctrl_low_d;
    logic [7:0] current_q;
    logic [7:0] current_d;
    logic [7:0] rdata_q;

    wire wr_high    = reg_write && (reg_addr == CTMC_ADDR_CTRL_HIGH);
    wire wr_low     = reg_write && (reg_addr == CTMC_ADDR_CTRL_LOW);
    wire wr_current = reg_write && (reg_addr == CTMC_ADDR_CURRENT);

    wire unit_enable             = ctrl_high_q[CTMC_BIT_UNIT_ENABLE];
    wire stop_in_idle            = ctrl_high_q[CTMC_BIT_STOP_IN_IDLE];
    wire delay_generation_enable = ctrl_high_q[CTMC_BIT_DELAY_GEN_ENABLE];
    wire edge_pass_enable        = ctrl_high_q[CTMC_BIT_EDGE_PASS_ENABLE];
    wire edge_ordering_enable    = ctrl_high_q[CTMC_BIT_EDGE_ORDER_ENABLE];
    wire current_ground_bit      = ctrl_high_q[CTMC_BIT_CURRENT_GROUND];
    wire special_trigger_enable  = ctrl_high_q[CTMC_BIT_SPECIAL_TRIG_ENABLE];
    wire first_edge_seen         = ctrl_low_q[CTMC_BIT_FIRST_SEEN];
    wire second_edge_seen        = ctrl_low_q[CTMC_BIT_SECOND_SEEN];

    // unit runs when enabled and not halted by idle
    wire idle_halt   = stop_in_idle && idle_mode;
    wire unit_active = unit_enable && !idle_halt;

    // ------------------------------------------------------------
    // select settling
    // ------------------------------------------------------------
    // the detector's previous level still belongs to the old source for
    // one cycle after a select write; events are held off for that cycle
    logic sel_settle_q;

    always_ff @(posedge uclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sel_settle_q <= 1'b0;
        end else begin
            sel_settle_q <= wr_low;
        end
    end

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    ctmc_edge_if edges ();

    assign edges.sources    = {pin_a_s, pin_b_s, capture_compare_a, capture_compare_b};
    assign edges.src_sel[1] = ctrl_low_q[CTMC_POS_SECOND_SOURCE +: 2];
    assign edges.src_sel[0] = ctrl_low_q[CTMC_POS_FIRST_SOURCE +: 2];
    assign edges.polarity   = {ctrl_low_q[CTMC_BIT_SECOND_POLARITY],
                               ctrl_low_q[CTMC_BIT_FIRST_POLARITY]};

    ctmc_edge_detect u_edge (
        .clk   (uclk),
        .rst_n (rst_n_q),
        .edges (edges)
    );

    wire edges_open  = unit_active && edge_pass_enable && !sel_settle_q;
    wire first_hit   = edges_open && edges.event_hit[0];
    wire second_ok   = !edge_ordering_enable || first_edge_seen;
    wire second_hit  = edges_open && edges.event_hit[1] && second_ok;

    // register next values; hardware set wins over a software clear
    always_comb begin
        ctrl_high_d = ctrl_high_q;
        ctrl_low_d  = ctrl_low_q;
        current_d   = current_q;
        if (wr_high) begin
            ctrl_high_d = reg_wdata & CTMC_HIGH_IMPL_MASK;
        end
        if (wr_low) begin
            ctrl_low_d = reg_wdata;
        end
        if (first_hit) begin
            ctrl_low_d[CTMC_BIT_FIRST_SEEN] = 1'b1;
        end
        if (second_hit) begin
            ctrl_low_d[CTMC_BIT_SECOND_SEEN] = 1'b1;
        end
        if (wr_current) begin
            current_d = reg_wdata;
        end
    end

    always_ff @(posedge uclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_high_q <= CTMC_RESET_CTRL_HIGH;
            ctrl_low_q  <= CTMC_RESET_CTRL_LOW;
            current_q   <= CTMC_RESET_CURRENT;
        end else begin
            ctrl_high_q <= ctrl_high_d;
            ctrl_low_q  <= ctrl_low_d;
            current_q   <= current_d;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_addr)
            CTMC_ADDR_CTRL_HIGH: rd_mux = ctrl_high_q;
            CTMC_ADDR_CTRL_LOW:  rd_mux = ctrl_low_q;
            CTMC_ADDR_CURRENT:   rd_mux = current_q;
            default:             rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge uclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_read ? rd_mux : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // analog controls
    // ------------------------------------------------------------
    logic       src_on_q;
    logic       ground_q;
    logic [1:0] range_q;
    logic [5:0] trim_q;
    logic       trig_q;

    wire range_nonzero = (current_q[CTMC_POS_RANGE +: 2] != CTMC_RANGE_OFF);
    wire src_on_d = unit_active && range_nonzero && first_edge_seen
                    && !second_edge_seen && !sleep_mode;

    always_ff @(posedge uclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            src_on_q <= 1'b0;
            ground_q <= 1'b0;
            range_q  <= CTMC_RANGE_OFF;
            trim_q   <= 6'h00;
            trig_q   <= 1'b0;
        end else begin
            src_on_q <= src_on_d;
            ground_q <= current_ground_bit;
            range_q  <= current_q[CTMC_POS_RANGE +: 2];
            trim_q   <= current_q[CTMC_POS_TRIM +: 6];
            trig_q   <= special_trigger_enable && second_hit;
        end
    end

    assign current_source_on     = src_on_q;
    assign current_source_ground = ground_q;
    assign current_range         = range_q;
    assign current_trim          = trim_q;
    assign special_trigger       = trig_q;

    // ------------------------------------------------------------
    // delay pulse sequencer
    // ------------------------------------------------------------
    ctmc_pulse_state_type pls_q;
    ctmc_pulse_state_type pls_d;

    wire pulse_armed = unit_active && delay_generation_enable && first_edge_seen;

    always_comb begin
        case (pls_q)
            CTMC_PLS_IDLE: pls_d = (pulse_armed && trip_s) ? CTMC_PLS_HIGH : CTMC_PLS_IDLE;
            CTMC_PLS_HIGH: pls_d = CTMC_PLS_DONE;
            CTMC_PLS_DONE: pls_d = pulse_armed ? CTMC_PLS_DONE : CTMC_PLS_IDLE;
            default:       pls_d = CTMC_PLS_IDLE;
        endcase
    end

    always_ff @(posedge uclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pls_q <= CTMC_PLS_IDLE;
        end else begin
            pls_q <= pls_d;
        end
    end
    assign delay_pulse_pin = (pls_q == CTMC_PLS_HIGH);

endmodule : ctmc_top

/* verification/charge_time_measure_control_bench.sv */
/*
  self-checking bench of the charge-time measurement control block.
  assumes ctmc_top, its package and the analog model are compiled first.
*/
`timescale 1ns/100ps
module charge_time_measure_control_bench;
    import ctmc_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, module_clock_disable = 1'b0, slow = 1'b0;
    logic       idle_mode = 1'b0, sleep_mode = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [3:0] src = 4'h0;
    logic       comparator_trip, current_source_on, current_source_ground;
    logic       delay_pulse_pin, special_trigger, pend = 1'b0;
    logic [1:0] current_range;
    logic [5:0] current_trim;
    logic [7:0] reg_rdata;
    logic [7:0] exp_q[$];
    int         mismatches = 0, checks = 0, n_trig = 0, n_pls = 0;

    always #10 clk = ~clk;

    ctmc_top i_dut (
        .clk, .nrst, .module_clock_disable, .idle_mode, .sleep_mode, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .edge_pin_a(src[3]), .edge_pin_b(src[2]),
        .capture_compare_a(src[1]), .capture_compare_b(src[0]), .comparator_trip,
        .current_source_on, .current_source_ground, .current_range, .current_trim,
        .delay_pulse_pin, .special_trigger
    );
    ctmc_analog_model i_ana (
        .clk, .slow, .source_on(current_source_on), .grounded(current_source_ground),
        .trip(comparator_trip)
    );

    // ----
    // tasks
    // ----
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t output %h expected %h", $time, got, exp);
        end
    endtask : chk_out
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= 2'(a);
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input int a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        reg_addr <= 2'(a);
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
    endtask : rd
    task automatic fire(input int s, input logic lvl);
        @(posedge clk);
        src[s[1:0]] <= lvl;
        cyc(8);
    endtask : fire
    task automatic rd_zero;
        for (int a = 0; a < 4; a++)
            rd(a, 8'h00);
        cyc(2);
    endtask : rd_zero

    // read answers and event pulses are taken at the falling edge
    always @(negedge clk) begin
        if (pend)
            chk8(reg_rdata, exp_q.pop_front());
        pend = reg_read;
        if (special_trigger)
            n_trig++;
        if (delay_pulse_pin)
            n_pls++;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test;
    end

    // ----
    // scenarios
    // ----
    initial begin
        logic [7:0] r;
        logic [7:0] cfg;
        logic [5:0] trims [4];
        void'($urandom(32'hb5c0c1c2));
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        cyc(3);
        rd_zero;
        r = 8'($urandom);
        trims = '{6'h1f, 6'h21, 6'h00, r[7:2]};
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom);
            wr(0, r & 8'h7f);
            rd(0, r & 8'h3f);
            wr(1, r);
            rd(1, r);
            wr(2, {trims[i], 2'(i)});
            cyc(2);
            chk_out(8'(current_trim), 8'(trims[i]));
            chk_out(8'(current_range), 8'(i));
        end
        wr(3, 8'hff);
        rd(3, 8'h00);
        wr(2, 8'h00);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            src <= {4{~k[2]}};
            cyc(6);
            cfg = {k[3] ? k[2] : ~k[2], 2'(k), k[3] ? ~k[2] : k[2], 2'(k), 2'h0};
            wr(1, cfg);
            wr(0, 8'h88);
            fire(k, k[2]);
            rd(1, cfg | (k[3] ? 8'h02 : 8'h01));
            wr(0, 8'h00);
        end
        for (int j = 0; j < 2; j++) begin
            fire(0, 1'b0);
            wr(1, 8'h90);
            wr(0, j ? 8'h80 : 8'h08);
            fire(0, 1'b1);
            rd(1, 8'h90);
        end
        wr(0, 8'h00);
        fire(1, 1'b0);
        fire(0, 1'b0);
        wr(1, 8'hb0);
        wr(0, 8'h8d);
        fire(1, 1'b1);
        rd(1, 8'hb0);
        fire(0, 1'b1);
        rd(1, 8'hb1);
        fire(1, 1'b0);
        fire(1, 1'b1);
        rd(1, 8'hb3);
        chk_out(8'(n_trig), 8'h01);
        wr(0, 8'h00);
        wr(2, 8'h01);
        wr(1, 8'h01);
        wr(0, 8'ha8);
        cyc(2);
        chk_out(8'(current_source_on), 8'h01);
        @(posedge clk) idle_mode <= 1'b1;
        cyc(2);
        chk_out(8'(current_source_on), 8'h00);
        @(posedge clk) idle_mode <= 1'b0;
        sleep_mode <= 1'b1;
        cyc(2);
        chk_out(8'(current_source_on), 8'h00);
        @(posedge clk) sleep_mode <= 1'b0;
        wr(1, 8'h03);
        cyc(2);
        chk_out(8'(current_source_on), 8'h00);
        wr(0, 8'h8a);
        cyc(2);
        chk_out(8'(current_source_ground), 8'h01);
        wr(0, 8'h88);
        cyc(2);
        chk_out(8'(current_source_ground), 8'h00);
        wr(1, 8'h00);
        wr(0, 8'h02);
        wr(0, 8'h98);
        wr(1, 8'h01);
        cyc(30);
        chk_out(8'(n_pls), 8'h01);
        wr(1, 8'h00);
        wr(0, 8'h02);
        @(posedge clk) slow <= 1'b1;
        wr(0, 8'h88);
        wr(1, 8'h01);
        cyc(70);
        chk_out(8'(n_pls), 8'h01);
        wr(2, 8'h05);
        @(posedge clk) module_clock_disable <= 1'b1;
        wr(2, 8'haa);
        @(posedge clk) module_clock_disable <= 1'b0;
        rd(2, 8'h05);
        @(posedge clk) nrst <= 1'b0;
        cyc(8);
        @(posedge clk) nrst <= 1'b1;
        cyc(3);
        rd_zero;
        chk_out(8'(current_source_on), 8'h00);
        stop_test;
    end
endmodule : charge_time_measure_control_bench

/* verification/ctmc_analog_model.sv */
/*
  behavioural capacitor and comparator seen by the current source outputs.
  assumes the same clock as the block; charge rises while the source drives.
*/
`timescale 1ns/100ps
module ctmc_analog_model (
    input  wire logic clk,       // clock
    input  wire logic slow,      // large capacitor, late trip
    input  wire logic source_on, // current flows
    input  wire logic grounded,  // source output tied low
    output logic      trip       // capacitor reached reference
);
    logic [7:0] charge_q = 8'h00;

    always_ff @(posedge clk) begin
        if (grounded)
            charge_q <= 8'h00;
        else if (source_on && charge_q != 8'hff)
            charge_q <= charge_q + 8'h01;
    end

    // charge holds while the source is off and not grounded, as a real capacitor would
    assign trip = charge_q >= (slow ? 8'h28 : 8'h04);
endmodule : ctmc_analog_model

/* verification/ctmc_top_sva.sv */
/*
  assertions on the ports of ctmc_top: readback, analog controls, pulses.
  assumes a bind to ctmc_top; register shadows follow the write port.
*/
`timescale 1ns/100ps
module ctmc_top_chk
    import ctmc_pkg::*;
(
    input wire logic       clk,                   // clock
    input wire logic       nrst,                  // reset, active low
    input wire logic       module_clock_disable,  // clock gate
    input wire logic       idle_mode,             // idle level
    input wire logic       sleep_mode,            // sleep level
    input wire logic [1:0] reg_addr,              // index
    input wire logic [7:0] reg_wdata,             // write data
    input wire logic       reg_write,             // write strobe
    input wire logic       reg_read,              // read strobe
    input wire logic [7:0] reg_rdata,             // read data
    input wire logic       current_source_on,     // source drives
    input wire logic       current_source_ground, // grounded
    input wire logic [1:0] current_range,         // range
    input wire logic [5:0] current_trim,          // trim
    input wire logic       delay_pulse_pin,       // delay pulse
    input wire logic       special_trigger        // trigger pulse
);
    // ----
    // register shadows and assertions
    // ----
    logic [7:0] hi_q;
    logic [7:0] cur_q;
    wire        wr_ok = reg_write && !module_clock_disable;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hi_q  <= CTMC_RESET_CTRL_HIGH;
            cur_q <= CTMC_RESET_CURRENT;
        end else if (wr_ok && reg_addr == CTMC_ADDR_CTRL_HIGH) begin
            hi_q <= reg_wdata & CTMC_HIGH_IMPL_MASK;
        end else if (wr_ok && reg_addr == CTMC_ADDR_CURRENT) begin
            cur_q <= reg_wdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    high_readback_a: assert property (
        reg_read && reg_addr == CTMC_ADDR_CTRL_HIGH |=> reg_rdata == $past(hi_q))
        else $error("first control register readback wrong");
    current_cfg_a: assert property (
        $changed(cur_q) |=> ##[0:1] (current_trim == cur_q[7:2] && current_range == cur_q[1:0]))
        else $error("trim or range output does not follow register");
    ground_follow_a: assert property (
        $changed(hi_q[1]) |=> ##[0:1] current_source_ground == hi_q[1])
        else $error("ground output does not follow control");
    sleep_off_a: assert property (sleep_mode |=> !current_source_on)
        else $error("current source on during sleep");
    idle_stop_a: assert property (idle_mode && hi_q[5] |=> !current_source_on)
        else $error("current source on in idle with stop set");
    source_gate_a: assert property (
        current_source_on |-> $past(hi_q[7]) && $past(cur_q[1:0]) != CTMC_RANGE_OFF)
        else $error("current source on while disabled or range off");
    trig_pulse_a: assert property (special_trigger |-> $past(hi_q[0]) ##1 !special_trigger)
        else $error("trigger pulse without enable or too long");
    delay_pulse_a: assert property (delay_pulse_pin |-> $past(hi_q[4]) ##1 !delay_pulse_pin)
        else $error("delay pulse without enable or too long");

    cover property (special_trigger);
    cover property (delay_pulse_pin);
    cover property (current_source_on ##1 sleep_mode);
    cover property (current_source_ground);
endmodule : ctmc_top_chk

bind ctmc_top ctmc_top_chk i_chk (
    .clk, .nrst, .module_clock_disable, .idle_mode, .sleep_mode, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .current_source_on, .current_source_ground,
    .current_range, .current_trim, .delay_pulse_pin, .special_trigger
);
